// ===== rtl/swn_crc8.sv
`timescale 1ns/1ns
module swn_crc8 (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clear,
	input wire logic shift,
	input wire logic din,
	output logic [7:0] crc
);
	logic fb;

	assign fb = din ^ crc[0];

	always_ff @(posedge mclk) begin
		if (rst || clear) begin
			crc <= swn_pkg::CRC_INIT;
		end else if (shift) begin
			crc <= (crc >> 1) ^ (fb ? swn_pkg::CRC_POLY_REFL : 8'h00);
		end
	end
endmodule

// ===== rtl/swn_device.sv
`timescale 1ns/1ns
// Overview of operation
// - top address byte is CRC of 56 bits
// - device never checks CRC; master verifies it
// - master clears register, shifts family then serial
// - drive line only by open-drain pull-down
// - master leaves line high when suspending
// - long low (120/16 us) is a reset
// - speed pin 0 standard, 1 overdrive
// - speed pin stable before reset; common speed
// - reset, address command, function command, data
// - master reset answered by presence pulse
// - read address opcode 33h or 39h by select
// - read address only with a single slave
// - match 55h: mismatch ignores until reset
// - skip CCh selects without any address
// - search F0h: bit, complement, master bit
// - match or search success sets resume flag
// - other device selected clears resume flag
// - address is family, 48-bit serial, CRC
module swn_device #(
	parameter logic [7:0] FAMILY = 8'h5A,
	parameter logic [47:0] SERIAL = 48'h0123456789AB
) (
	input wire logic mclk,
	input wire logic rst,
	swn_link_if.device link,
	input wire logic read_addr_opcode_select,
	input wire logic fn_tx_en,
	input wire logic fn_tx_bit,
	output logic selected,
	output logic resume_flag,
	output logic fn_valid,
	output logic fn_bit
);
	// FAMILY and SERIAL defaults are arbitrary values.

	typedef enum logic [1:0] {L_IDLE, L_SLOT, L_RST, L_PRES} swn_lnk_e;
	typedef enum logic [2:0] {
		P_IGNORE, P_CMD, P_READ, P_MATCH, P_SRCH_A, P_SRCH_B, P_SRCH_W, P_SEL
	} swn_prt_e;

	swn_lnk_e lnk_q;
	swn_prt_e prt_q;
	swn_pkg::swn_cnt_t cnt_q;
	logic pres_drive_q;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic ovd1_q;
	logic ovd_q;
	logic slot_evt;
	logic rst_evt;
	logic tx_active;
	logic tx_bit;
	logic [7:0] cmd_q;
	logic [5:0] idx_q;
	logic match_ok_q;
	logic [5:0] init_q;
	logic init_done_q;
	logic [7:0] crc;
	logic [63:0] addr;
	swn_pkg::swn_cnt_t mid_cyc;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q <= 1'b1;
			ovd1_q <= 1'b0;
			ovd_q <= 1'b0;
		end else begin
			sync1_q <= link.dq;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			ovd1_q <= link.speed_sel;
			ovd_q <= ovd1_q;
		end
	end

	// ----------------------------------------------------------------
	// Factory address and its check code
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			init_q <= '0;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_q <= init_q + 6'h01;
			if (init_q == 6'(swn_pkg::CRC_DATA_BITS - 1)) begin
				init_done_q <= 1'b1;
			end
		end
	end

	// Family code is shifted first from its low bit, then the serial number.
	swn_crc8 u_crc (
		.mclk(mclk),
		.rst(rst),
		.clear(1'b0),
		.shift(~init_done_q),
		.din(addr[init_q]),
		.crc(crc)
	);

	assign addr = {crc, SERIAL, FAMILY};

	// ----------------------------------------------------------------
	// Link timing: slots, reset detection and presence
	// ----------------------------------------------------------------
	assign mid_cyc = swn_pkg::swn_pick(ovd_q, swn_pkg::DEV_MID_STD_CYC,
		swn_pkg::DEV_MID_OVD_CYC);
	assign slot_evt = (lnk_q == L_SLOT) && (cnt_q == mid_cyc);
	assign rst_evt = (lnk_q == L_SLOT) && (cnt_q == swn_pkg::swn_pick(ovd_q,
		swn_pkg::DEV_RST_STD_CYC, swn_pkg::DEV_RST_OVD_CYC));

	// Only a pull-down is ever enabled; release leaves the line to the pull-up.
	assign link.dev_oe = pres_drive_q ||
		(lnk_q == L_SLOT && tx_active && !tx_bit && cnt_q < mid_cyc);

	always_ff @(posedge mclk) begin
		if (rst) begin
			lnk_q <= L_IDLE;
			cnt_q <= '0;
			pres_drive_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 12'h001;
			case (lnk_q)
				L_IDLE: begin
					cnt_q <= '0;
					if (prev_q && !sync2_q) begin
						lnk_q <= L_SLOT;
					end
				end
				L_SLOT: begin
					if (rst_evt) begin
						lnk_q <= L_RST;
					end else if (cnt_q >= mid_cyc && sync2_q) begin
						lnk_q <= L_IDLE;
					end
				end
				L_RST: begin
					cnt_q <= '0;
					if (sync2_q) begin
						lnk_q <= L_PRES;
					end
				end
				L_PRES: begin
					// Only the wait before the pulse may restart the count.
					if (!pres_drive_q && cnt_q == swn_pkg::swn_pick(ovd_q,
							swn_pkg::DEV_PDH_STD_CYC, swn_pkg::DEV_PDH_OVD_CYC)) begin
						pres_drive_q <= 1'b1;
						cnt_q <= '0;
					end
					if (pres_drive_q && cnt_q == swn_pkg::swn_pick(ovd_q,
							swn_pkg::DEV_PDL_STD_CYC, swn_pkg::DEV_PDL_OVD_CYC)) begin
						pres_drive_q <= 1'b0;
						lnk_q <= L_IDLE;
					end
				end
				default: begin
					lnk_q <= L_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Net address commands
	// ----------------------------------------------------------------
	always_comb begin
		tx_active = 1'b0;
		tx_bit = 1'b1;
		case (prt_q)
			P_READ, P_SRCH_A: begin
				tx_active = 1'b1;
				tx_bit = addr[idx_q];
			end
			P_SRCH_B: begin
				tx_active = 1'b1;
				tx_bit = ~addr[idx_q];
			end
			P_SEL: begin
				tx_active = fn_tx_en;
				tx_bit = fn_tx_bit;
			end
			default: begin
				tx_active = 1'b0;
				tx_bit = 1'b1;
			end
		endcase
	end

	// The check code is compared here only as address bits in match and search; a bad one is the master's concern.
	always_ff @(posedge mclk) begin
		if (rst) begin
			prt_q <= P_IGNORE;
			cmd_q <= '0;
			idx_q <= '0;
			match_ok_q <= 1'b0;
			resume_flag <= 1'b0;
			fn_valid <= 1'b0;
			fn_bit <= 1'b0;
		end else begin
			fn_valid <= 1'b0;
			if (rst_evt) begin
				prt_q <= init_done_q ? P_CMD : P_IGNORE;
				idx_q <= '0;
				cmd_q <= '0;
			end else if (slot_evt) begin
				case (prt_q)
					P_CMD: begin
						cmd_q <= {sync2_q, cmd_q[7:1]};
						idx_q <= idx_q + 6'h01;
						if (idx_q == 6'h07) begin
							idx_q <= '0;
							match_ok_q <= 1'b1;
							case ({sync2_q, cmd_q[7:1]})
								swn_pkg::OP_READ_A: begin
									prt_q <= read_addr_opcode_select ? P_IGNORE : P_READ;
								end
								swn_pkg::OP_READ_B: begin
									prt_q <= read_addr_opcode_select ? P_READ : P_IGNORE;
								end
								swn_pkg::OP_MATCH: begin
									prt_q <= P_MATCH;
								end
								swn_pkg::OP_SKIP: begin
									prt_q <= P_SEL;
								end
								swn_pkg::OP_SEARCH: begin
									prt_q <= P_SRCH_A;
								end
								swn_pkg::OP_RESUME: begin
									prt_q <= resume_flag ? P_SEL : P_IGNORE;
								end
								default: begin
									prt_q <= P_IGNORE;
								end
							endcase
						end
					end
					P_READ: begin
						idx_q <= idx_q + 6'h01;
						if (idx_q == 6'h3F) begin
							prt_q <= P_SEL;
						end
					end
					P_MATCH: begin
						idx_q <= idx_q + 6'h01;
						if (idx_q == 6'h3F) begin
							if (match_ok_q && sync2_q == addr[idx_q]) begin
								prt_q <= P_SEL;
								resume_flag <= 1'b1;
							end else begin
								prt_q <= P_IGNORE;
								resume_flag <= 1'b0;
							end
						end else if (sync2_q != addr[idx_q]) begin
							match_ok_q <= 1'b0;
						end
					end
					P_SRCH_A: begin
						prt_q <= P_SRCH_B;
					end
					P_SRCH_B: begin
						prt_q <= P_SRCH_W;
					end
					P_SRCH_W: begin
						idx_q <= idx_q + 6'h01;
						if (sync2_q != addr[idx_q]) begin
							prt_q <= P_IGNORE;
							resume_flag <= 1'b0;
						end else if (idx_q == 6'h3F) begin
							prt_q <= P_SEL;
							resume_flag <= 1'b1;
						end else begin
							prt_q <= P_SRCH_A;
						end
					end
					P_SEL: begin
						fn_valid <= 1'b1;
						fn_bit <= sync2_q;
					end
					default: begin
						prt_q <= P_IGNORE;
					end
				endcase
			end
		end
	end

	assign selected = (prt_q == P_SEL);
endmodule

// ===== rtl/swn_host.sv
`timescale 1ns/1ns
module swn_host (
	input wire logic mclk,
	input wire logic rst,
	swn_link_if.host link,
	input wire logic speed,
	input wire logic req_valid,
	input wire swn_pkg::swn_req_e req_kind,
	input wire logic req_bit,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_bit,
	input wire logic crc_clear,
	input wire logic crc_shift,
	input wire logic crc_in,
	output logic [7:0] crc_value
);
	typedef enum logic [1:0] {H_IDLE, H_RST_LOW, H_RST_WAIT, H_SLOT} swn_hst_e;

	swn_hst_e state_q;
	swn_pkg::swn_cnt_t cnt_q;
	swn_pkg::swn_cnt_t low_q;
	logic ovd_q;
	logic samp_q;
	logic sync1_q;
	logic sync2_q;

	// ----------------------------------------------------------------
	// Line input and speed pin
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= link.dq;
			sync2_q <= sync1_q;
		end
	end

	// The speed level only changes between transfers, so it is stable at each reset.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovd_q <= 1'b0;
		end else if (state_q == H_IDLE) begin
			ovd_q <= speed;
		end
	end

	assign link.speed_sel = ovd_q;
	assign req_ready = (state_q == H_IDLE);
	// Outside a reset or a slot the line is always left to the pull-up.
	assign link.host_oe = (state_q == H_RST_LOW) ||
		(state_q == H_SLOT && cnt_q < low_q);

	// ----------------------------------------------------------------
	// Reset, write and read sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= H_IDLE;
			cnt_q <= '0;
			low_q <= '0;
			samp_q <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_bit <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			cnt_q <= cnt_q + 12'h001;
			case (state_q)
				H_IDLE: begin
					cnt_q <= '0;
					if (req_valid) begin
						case (req_kind)
							swn_pkg::SWN_REQ_RESET: begin
								state_q <= H_RST_LOW;
							end
							swn_pkg::SWN_REQ_WRITE: begin
								state_q <= H_SLOT;
								low_q <= req_bit ?
									swn_pkg::swn_pick(ovd_q, swn_pkg::HST_W1_STD_CYC,
										swn_pkg::HST_W1_OVD_CYC) :
									swn_pkg::swn_pick(ovd_q, swn_pkg::HST_W0_STD_CYC,
										swn_pkg::HST_W0_OVD_CYC);
							end
							default: begin
								state_q <= H_SLOT;
								low_q <= swn_pkg::swn_pick(ovd_q, swn_pkg::HST_RDL_STD_CYC,
									swn_pkg::HST_RDL_OVD_CYC);
							end
						endcase
					end
				end
				H_RST_LOW: begin
					if (cnt_q == swn_pkg::swn_pick(ovd_q, swn_pkg::HST_RSTL_STD_CYC,
							swn_pkg::HST_RSTL_OVD_CYC) - 12'h001) begin
						state_q <= H_RST_WAIT;
						cnt_q <= '0;
					end
				end
				H_RST_WAIT: begin
					if (cnt_q == swn_pkg::swn_pick(ovd_q, swn_pkg::HST_PSAMP_STD_CYC,
							swn_pkg::HST_PSAMP_OVD_CYC)) begin
						samp_q <= sync2_q;
					end
					if (cnt_q == swn_pkg::swn_pick(ovd_q, swn_pkg::HST_PWAIT_STD_CYC,
							swn_pkg::HST_PWAIT_OVD_CYC) - 12'h001) begin
						state_q <= H_IDLE;
						rsp_valid <= 1'b1;
						rsp_bit <= ~samp_q;
					end
				end
				H_SLOT: begin
					if (cnt_q == swn_pkg::swn_pick(ovd_q, swn_pkg::HST_RSAMP_STD_CYC,
							swn_pkg::HST_RSAMP_OVD_CYC)) begin
						samp_q <= sync2_q;
					end
					if (cnt_q == swn_pkg::swn_pick(ovd_q, swn_pkg::HST_SLOT_STD_CYC,
							swn_pkg::HST_SLOT_OVD_CYC) - 12'h001) begin
						state_q <= H_IDLE;
						rsp_valid <= 1'b1;
						rsp_bit <= samp_q;
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Address check code
	// ----------------------------------------------------------------
	swn_crc8 u_crc (
		.mclk(mclk),
		.rst(rst),
		.clear(crc_clear),
		.shift(crc_shift),
		.din(crc_in),
		.crc(crc_value)
	);
endmodule

// ===== rtl/swn_link_if.sv
`timescale 1ns/1ns
interface swn_link_if;
	logic dev_oe;
	logic host_oe;
	logic speed_sel;
	wire dq;

	// The pull-up holds the line high; any enabled pull-down takes it low.
	assign dq = ~(dev_oe | host_oe);

	modport device(output dev_oe, input dq, input speed_sel);
	modport host(output host_oe, output speed_sel, input dq);
endinterface

// ===== rtl/swn_pkg.sv
package swn_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int MCLK_NS = 40;

	typedef logic [11:0] swn_cnt_t;

	// Converts a time in microseconds to whole mclk cycles, rounding up.
	function automatic swn_cnt_t swn_us_to_cyc(input int us);
		return swn_cnt_t'((us * 1000 + MCLK_NS - 1) / MCLK_NS);
	endfunction

	// Chooses the standard or the overdrive figure from the speed level.
	function automatic swn_cnt_t swn_pick(input logic speed_select_pin, input swn_cnt_t std_v,
			input swn_cnt_t ovd_v);
		return speed_select_pin ? ovd_v : std_v;
	endfunction

	// ----------------------------------------------------------------
	// Slave timing
	// ----------------------------------------------------------------
	localparam int DEV_RST_STD_US = 120;
	localparam int DEV_RST_OVD_US = 16;
	localparam int DEV_MID_STD_US = 30;
	localparam int DEV_MID_OVD_US = 4;
	localparam int DEV_PDH_STD_US = 15;
	localparam int DEV_PDH_OVD_US = 2;
	localparam int DEV_PDL_STD_US = 60;
	localparam int DEV_PDL_OVD_US = 8;
	localparam swn_cnt_t DEV_RST_STD_CYC = swn_us_to_cyc(DEV_RST_STD_US);
	localparam swn_cnt_t DEV_RST_OVD_CYC = swn_us_to_cyc(DEV_RST_OVD_US);
	localparam swn_cnt_t DEV_MID_STD_CYC = swn_us_to_cyc(DEV_MID_STD_US);
	localparam swn_cnt_t DEV_MID_OVD_CYC = swn_us_to_cyc(DEV_MID_OVD_US);
	localparam swn_cnt_t DEV_PDH_STD_CYC = swn_us_to_cyc(DEV_PDH_STD_US);
	localparam swn_cnt_t DEV_PDH_OVD_CYC = swn_us_to_cyc(DEV_PDH_OVD_US);
	localparam swn_cnt_t DEV_PDL_STD_CYC = swn_us_to_cyc(DEV_PDL_STD_US);
	localparam swn_cnt_t DEV_PDL_OVD_CYC = swn_us_to_cyc(DEV_PDL_OVD_US);

	// ----------------------------------------------------------------
	// Master timing
	// ----------------------------------------------------------------
	localparam int HST_RSTL_STD_US = 130;
	localparam int HST_RSTL_OVD_US = 70;
	localparam int HST_PSAMP_STD_US = 40;
	localparam int HST_PSAMP_OVD_US = 5;
	localparam int HST_PWAIT_STD_US = 120;
	localparam int HST_PWAIT_OVD_US = 16;
	localparam int HST_SLOT_STD_US = 70;
	localparam int HST_SLOT_OVD_US = 10;
	localparam int HST_W0_STD_US = 60;
	localparam int HST_W0_OVD_US = 6;
	localparam int HST_W1_STD_US = 6;
	localparam int HST_W1_OVD_US = 1;
	localparam int HST_RDL_STD_US = 2;
	localparam int HST_RDL_OVD_US = 1;
	localparam int HST_RSAMP_STD_US = 14;
	localparam int HST_RSAMP_OVD_US = 2;
	localparam swn_cnt_t HST_RSTL_STD_CYC = swn_us_to_cyc(HST_RSTL_STD_US);
	localparam swn_cnt_t HST_RSTL_OVD_CYC = swn_us_to_cyc(HST_RSTL_OVD_US);
	localparam swn_cnt_t HST_PSAMP_STD_CYC = swn_us_to_cyc(HST_PSAMP_STD_US);
	localparam swn_cnt_t HST_PSAMP_OVD_CYC = swn_us_to_cyc(HST_PSAMP_OVD_US);
	localparam swn_cnt_t HST_PWAIT_STD_CYC = swn_us_to_cyc(HST_PWAIT_STD_US);
	localparam swn_cnt_t HST_PWAIT_OVD_CYC = swn_us_to_cyc(HST_PWAIT_OVD_US);
	localparam swn_cnt_t HST_SLOT_STD_CYC = swn_us_to_cyc(HST_SLOT_STD_US);
	localparam swn_cnt_t HST_SLOT_OVD_CYC = swn_us_to_cyc(HST_SLOT_OVD_US);
	localparam swn_cnt_t HST_W0_STD_CYC = swn_us_to_cyc(HST_W0_STD_US);
	localparam swn_cnt_t HST_W0_OVD_CYC = swn_us_to_cyc(HST_W0_OVD_US);
	localparam swn_cnt_t HST_W1_STD_CYC = swn_us_to_cyc(HST_W1_STD_US);
	localparam swn_cnt_t HST_W1_OVD_CYC = swn_us_to_cyc(HST_W1_OVD_US);
	localparam swn_cnt_t HST_RDL_STD_CYC = swn_us_to_cyc(HST_RDL_STD_US);
	localparam swn_cnt_t HST_RDL_OVD_CYC = swn_us_to_cyc(HST_RDL_OVD_US);
	localparam swn_cnt_t HST_RSAMP_STD_CYC = swn_us_to_cyc(HST_RSAMP_STD_US);
	localparam swn_cnt_t HST_RSAMP_OVD_CYC = swn_us_to_cyc(HST_RSAMP_OVD_US);

	// ----------------------------------------------------------------
	// Address, check code and opcodes
	// ----------------------------------------------------------------
	localparam int ADDR_BITS = 64;
	localparam int CRC_DATA_BITS = 56;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] OP_READ_A = 8'h33;
	localparam logic [7:0] OP_READ_B = 8'h39;
	localparam logic [7:0] OP_MATCH = 8'h55;
	localparam logic [7:0] OP_SKIP = 8'hCC;
	localparam logic [7:0] OP_SEARCH = 8'hF0;
	localparam logic [7:0] OP_RESUME = 8'hA5;

	typedef enum logic [1:0] {
		SWN_REQ_RESET,
		SWN_REQ_WRITE,
		SWN_REQ_READ
	} swn_req_e;

endpackage

// ===== test/swn_link_properties.sv
`timescale 1ns/1ns
module swn_link_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic dev_oe,
	input wire logic host_oe,
	input wire logic speed_sel,
	input wire logic dq
);
	// ----------------------------------------------------------------
	// Run lengths of each party's pull-down
	// ----------------------------------------------------------------
	logic [11:0] host_lo_q;
	logic [11:0] dev_hi_q;

	always_ff @(posedge mclk) begin
		if (rst || !host_oe) begin
			host_lo_q <= 12'h000;
		end else if (host_lo_q != 12'hFFF) begin
			host_lo_q <= host_lo_q + 12'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !dev_oe) begin
			dev_hi_q <= 12'h000;
		end else if (dev_hi_q != 12'hFFF) begin
			dev_hi_q <= dev_hi_q + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// A host release after a low longer than any slot ends a bus reset.
	sequence rel_s;
		$fell(host_oe) && host_lo_q >= 12'h640;
	endsequence

	a_idle_high: assert property (!dev_oe && !host_oe |-> dq)
		else $error("line not high while released");
	a_reset_quiet: assert property ($fell(rst) |-> !dev_oe && !host_oe)
		else $error("line driven after reset");
	a_std_presence: assert property (rel_s and !speed_sel |-> ##[340:420] dev_oe)
		else $error("no standard presence pulse");
	a_ovd_presence: assert property (rel_s and speed_sel |-> ##[40:80] dev_oe)
		else $error("no overdrive presence pulse");
	a_presence_wait: assert property (rel_s |-> ##1 (!dev_oe) [*8])
		else $error("presence pulse too early");
	a_drive_bounded: assert property (dev_hi_q <= 12'h5F0)
		else $error("device holds line too long");
	a_ovd_drive_short: assert property (speed_sel |-> dev_hi_q <= 12'h0D2)
		else $error("overdrive pull-down too long");
	a_long_low_silent: assert property (host_lo_q >= 12'h064 |-> !dev_oe)
		else $error("device drives during long low");
	a_host_low_bounded: assert property (host_lo_q <= 12'hCB2)
		else $error("host holds line longer than a reset");

	cover property (rel_s and !speed_sel);
	cover property (rel_s and speed_sel);
	cover property ($rose(dev_oe) && speed_sel);
endmodule

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
	// Address of the device under test; the values are arbitrary.
	localparam logic [7:0] FAM = 8'h5A;
	localparam logic [47:0] SER = 48'h0123456789AB;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic speed = 1'b0;
	logic req_valid = 1'b0;
	swn_pkg::swn_req_e req_kind = swn_pkg::SWN_REQ_RESET;
	logic req_bit = 1'b0;
	logic req_ready;
	logic rsp_valid;
	logic rsp_bit;
	logic crc_clear = 1'b0;
	logic crc_shift = 1'b0;
	logic crc_in = 1'b0;
	logic [7:0] crc_value;
	logic sel_op = 1'b0;
	logic fn_tx_en = 1'b0;
	logic fn_tx_bit = 1'b0;
	logic selected;
	logic resume_flag;
	logic fn_valid;
	logic fn_bit;
	int fails = 0;
	int cmp_count = 0;
	int fn_cnt = 0;

	initial forever #20 mclk = ~mclk;

	// Counts the one-cycle function bit strobes; each spans one falling edge.
	always @(negedge mclk) begin
		if (fn_valid === 1'b1) begin
			fn_cnt++;
		end
	end

	swn_link_if link();

	swn_host i_swn_host (.mclk(mclk), .rst(rst), .link(link), .speed(speed),
		.req_valid(req_valid), .req_kind(req_kind), .req_bit(req_bit), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_bit(rsp_bit), .crc_clear(crc_clear),
		.crc_shift(crc_shift), .crc_in(crc_in), .crc_value(crc_value));

	swn_device #(.FAMILY(FAM), .SERIAL(SER)) i_swn_device (.mclk(mclk), .rst(rst),
		.link(link), .read_addr_opcode_select(sel_op), .fn_tx_en(fn_tx_en),
		.fn_tx_bit(fn_tx_bit), .selected(selected), .resume_flag(resume_flag),
		.fn_valid(fn_valid), .fn_bit(fn_bit));

	swn_link_properties i_swn_link_properties (.mclk(mclk), .rst(rst),
		.dev_oe(link.dev_oe), .host_oe(link.host_oe), .speed_sel(link.speed_sel),
		.dq(link.dq));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			fb = c[0] ^ d[i];
			c = c >> 1;
			if (fb) begin
				c = c ^ swn_pkg::CRC_POLY_REFL;
			end
		end
		return c;
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t %s", $time, what);
		end
	endtask

	// One host request, entered at a falling edge; returns at the answer.
	task automatic xfer(input swn_pkg::swn_req_e k, input logic b, output logic r);
		int n;
		req_kind = k;
		req_bit = b;
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 8000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 8000) begin
			fails++;
			$display("ERROR t=%0t no answer", $time);
			report_and_stop();
		end
		r = rsp_bit;
	endtask

	task automatic send(input logic [63:0] v, input int n);
		logic r;
		for (int i = 0; i < n; i++) begin
			xfer(swn_pkg::SWN_REQ_WRITE, v[i], r);
		end
	endtask

	task automatic recv(input int n, output logic [63:0] v);
		logic r;
		v = 64'h0;
		for (int i = 0; i < n; i++) begin
			xfer(swn_pkg::SWN_REQ_READ, 1'b1, r);
			v[i] = r;
		end
	endtask

	// Bus reset at the given speed, then one address opcode.
	task automatic open(input logic spd, input logic [7:0] op);
		logic r;
		speed = spd;
		@(negedge mclk);
		xfer(swn_pkg::SWN_REQ_RESET, 1'b0, r);
		check(r, 64'h1, "presence");
		send(op, 8);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		logic [63:0] v;
		logic r;
		logic [63:0] addr;
		addr = {crc8({SER, FAM}), SER, FAM};
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (60) @(negedge mclk);
		check(resume_flag, 64'h0, "flag after reset");
		open(1'b0, swn_pkg::OP_SKIP);
		check(selected, 64'h1, "skip selects");
		send(64'h1, 1);
		check(fn_bit, 64'h1, "function bit one");
		send(64'h0, 1);
		check(fn_bit, 64'h0, "function bit zero");
		check(fn_cnt, 64'h2, "function bit strobes");
		check(req_ready, 64'h1, "host ready after answer");
		fn_tx_en = 1'b1;
		xfer(swn_pkg::SWN_REQ_READ, 1'b1, r);
		fn_tx_en = 1'b0;
		check(r, 64'h0, "function answer");
		$display("test standard skip done");
		open(1'b1, swn_pkg::OP_READ_A);
		recv(64, v);
		check(v, addr, "address read");
		crc_clear = 1'b1;
		@(negedge mclk);
		crc_clear = 1'b0;
		crc_shift = 1'b1;
		for (int i = 0; i < 56; i++) begin
			crc_in = v[i];
			@(negedge mclk);
		end
		crc_shift = 1'b0;
		@(negedge mclk);
		check(crc_value, v[63:56], "host check code");
		$display("test read address done");
		sel_op = 1'b1;
		open(1'b1, swn_pkg::OP_READ_A);
		recv(8, v);
		check(v, 64'hFF, "wrong read opcode ignored");
		open(1'b1, swn_pkg::OP_READ_B);
		recv(8, v);
		check(v, {56'h0, FAM}, "alternate read opcode");
		sel_op = 1'b0;
		$display("test read opcode select done");
		open(1'b1, swn_pkg::OP_MATCH);
		send(addr, 64);
		check(selected, 64'h1, "match selects");
		check(resume_flag, 64'h1, "match sets flag");
		open(1'b1, swn_pkg::OP_RESUME);
		check(selected, 64'h1, "resume selects");
		$display("test match and resume done");
		open(1'b1, swn_pkg::OP_SEARCH);
		xfer(swn_pkg::SWN_REQ_READ, 1'b1, r);
		check(r, FAM[0], "search bit");
		xfer(swn_pkg::SWN_REQ_READ, 1'b1, r);
		check(r, {63'h0, ~FAM[0]}, "search complement");
		xfer(swn_pkg::SWN_REQ_WRITE, ~FAM[0], r);
		recv(2, v);
		check(v, 64'h3, "search drop out");
		check(resume_flag, 64'h0, "flag cleared");
		open(1'b1, swn_pkg::OP_RESUME);
		check(selected, 64'h0, "resume refused");
		$display("test search drop out done");
		report_and_stop();
	end
endmodule
